// >>> hw/dwss_slave.sv
`timescale 1ns/100ps

// What this block does
// RULE_01: Nothing happens on the bus until a start condition is seen.
// RULE_02: Stop is data rising while clock high; it ends every operation.
// RULE_03: Master keeps data stable while clock is high during data bits.
// RULE_04: The receiver pulls data low in the ninth clock of each byte.
// RULE_05: Acknowledge a matching address byte, stay silent for any other.
// RULE_06: Once addressed for write, acknowledge every following byte.
// RULE_07: In read, send eight bits, release data, sample master ack.
// RULE_08: Without master ack, stop sending and wait for a stop.
// RULE_09: Master writes address, instruction, data, each acked, then stop.
// RULE_10: Write carries three bytes, read carries two.
// RULE_11: Top seven address bits identify device; last two follow straps.
// RULE_12: Address LSB high starts a read, low starts a write.
// RULE_13: Instruction MSB picks wiper one when low, wiper two when high.
// RULE_14: Shutdown bit opens terminal A, wiper to B, value kept.
// RULE_15: Shutdown low drives wiper from the stored register again.
// RULE_16: Writes during shutdown are stored and used after shutdown.
// RULE_17: The other six instruction bits are ignored.
// RULE_18: Read data starts right after the address acknowledge.
// RULE_19: Read returns the wiper chosen by the latest instruction byte.
// RULE_20: A write ending after instruction only changes the selection and shutdown bits.
// RULE_21: Two 8-bit wipers, each decoded to a one-of-256 tap select.
// RULE_22: Wipers are volatile and load midscale at power-up.
// RULE_23: Midscale value is hexadecimal 80.
// RULE_24: Read repeats the selected wiper while the master acknowledges.
module dwss_slave
	import dwss_pkg::*;
#(
	parameter logic [4:0] ID_PREFIX = 5'h15, // Arbitrary identifier value
	parameter logic       STRAP_EN  = 1'b1,
	parameter logic [1:0] ID_LOW    = 2'h0   // Arbitrary, used without straps
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         scl_in,
	input  wire logic         sda_in,
	output logic              sda_out,
	output logic              sda_oe,
	input  wire logic         address_strap_high,
	input  wire logic         address_strap_low,
	output logic [7:0]        wiper_position_one,
	output logic [7:0]        wiper_position_two,
	output logic              channel_select_bit,
	output logic              shutdown_bit,
	output logic              terminal_a_open,
	output logic [255:0]      tap_select_one,
	output logic [255:0]      tap_select_two
);

	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [1:0] ahi_sync_q;
	logic [1:0] alo_sync_q;
	logic       scl_prev_q;
	logic       sda_prev_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			ahi_sync_q <= 2'h0;
			alo_sync_q <= 2'h0;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], scl_in};
			sda_sync_q <= {sda_sync_q[0], sda_in};
			ahi_sync_q <= {ahi_sync_q[0], address_strap_high};
			alo_sync_q <= {alo_sync_q[0], address_strap_low};
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	wire scl_s = scl_sync_q[1];
	wire sda_s = sda_sync_q[1];

	// Any data change while clock is high is framing, never data
	wire scl_high  = scl_s & scl_prev_q;
	wire start_det = scl_high & sda_prev_q & ~sda_s;     // RULE_01 RULE_03
	wire stop_det  = scl_high & ~sda_prev_q & sda_s;     // RULE_02 RULE_03
	wire scl_rise  = scl_s & ~scl_prev_q;
	wire scl_fall  = ~scl_s & scl_prev_q;
	wire framing   = start_det | stop_det;

	// -----------------------------------------------------------------
	// Sequencer registers
	// -----------------------------------------------------------------
	dwss_state_type state_q;
	dwss_state_type state_d;
	logic [3:0]     cnt_q;
	logic [3:0]     cnt_d;
	logic [7:0]     shift_q;
	logic [7:0]     shift_d;
	logic           oe_q;
	logic           oe_d;
	logic           rw_q;
	logic           rw_d;
	logic           mack_q;
	logic           mack_d;
	logic           sel_q;
	logic           sel_d;
	logic           sd_q;
	logic           sd_d;
	logic [7:0]     w1_q;
	logic [7:0]     w2_q;
	logic [255:0]   tap1_q;
	logic [255:0]   tap2_q;

	// -----------------------------------------------------------------
	// Decode
	// -----------------------------------------------------------------
	wire [1:0] id_low   = STRAP_EN ? {ahi_sync_q[1], alo_sync_q[1]} : ID_LOW;
	wire [6:0] dev_id   = {ID_PREFIX, id_low};                  // RULE_11
	wire       addr_hit = (shift_q[7:1] == dev_id);             // RULE_05
	wire       byte_end = scl_fall & (cnt_q == BYTE_BITS) & ~framing;
	wire       wr_one   = (state_q == S_DATA) & byte_end & ~sel_q;
	wire       wr_two   = (state_q == S_DATA) & byte_end & sel_q;
	wire [7:0] rd_val   = sel_q ? w2_q : w1_q;                  // RULE_19

	// -----------------------------------------------------------------
	// Next state
	// -----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		shift_d = shift_q;
		oe_d    = oe_q;
		rw_d    = rw_q;
		mack_d  = mack_q;
		sel_d   = sel_q;
		sd_d    = sd_q;
		if (start_det) begin
			state_d = S_ADDR;
			cnt_d   = 4'h0;
			oe_d    = 1'b0;
		end else if (stop_det) begin
			state_d = S_IDLE;
			oe_d    = 1'b0;
		end else begin
			unique case (state_q)
				S_IDLE, S_WAIT_STOP: begin
				end
				S_ADDR, S_INSTR, S_DATA: begin
					if (scl_rise && cnt_q != BYTE_BITS) begin
						shift_d = {shift_q[6:0], sda_s};
						cnt_d   = cnt_q + 4'h1;
					end else if (byte_end) begin
						oe_d = 1'b1;                                  // RULE_04
						if (state_q == S_ADDR) begin
							rw_d    = shift_q[RW_BIT];                    // RULE_12
							state_d = addr_hit ? S_ADDR_ACK : S_WAIT_STOP;
							oe_d    = addr_hit;                           // RULE_05
						end else if (state_q == S_INSTR) begin
							// Low six bits are don't care
							sel_d   = shift_q[SEL_BIT];               // RULE_13 RULE_17
							sd_d    = shift_q[SD_BIT];                // RULE_14 RULE_20
							state_d = S_INSTR_ACK;
						end else begin
							state_d = S_DATA_ACK;                 // RULE_06 RULE_10
						end
					end
				end
				S_ADDR_ACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							state_d = S_TX;                               // RULE_18
							shift_d = rd_val;
							oe_d    = ~rd_val[7];
						end else begin
							state_d = S_INSTR;
							oe_d    = 1'b0;
						end
					end
				end
				S_INSTR_ACK, S_DATA_ACK: begin
					if (scl_fall) begin
						// Extra bytes are acked and overwrite the wiper
						state_d = S_DATA;                                 // RULE_06
						cnt_d   = 4'h0;
						oe_d    = 1'b0;
					end
				end
				S_TX: begin
					if (scl_rise && cnt_q != BYTE_BITS) begin
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (cnt_q == BYTE_BITS) begin
							state_d = S_TX_ACK;                           // RULE_07
							oe_d    = 1'b0;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							oe_d    = ~shift_q[6];
						end
					end
				end
				S_TX_ACK: begin
					if (scl_rise) begin
						mack_d = ~sda_s;                                  // RULE_07
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (mack_q) begin
							state_d = S_TX;                               // RULE_24
							shift_d = rd_val;
							oe_d    = ~rd_val[7];
						end else begin
							state_d = S_WAIT_STOP;                        // RULE_08
						end
					end
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Sequencer flops
	// -----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= S_IDLE;                                        // RULE_01
			cnt_q   <= 4'h0;
			shift_q <= 8'h00;
			oe_q    <= 1'b0;
			rw_q    <= 1'b0;
			mack_q  <= 1'b0;
			sel_q   <= 1'b0;
			sd_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			shift_q <= shift_d;
			oe_q    <= oe_d;
			rw_q    <= rw_d;
			mack_q  <= mack_d;
			sel_q   <= sel_d;
			sd_q    <= sd_d;
		end
	end

	// -----------------------------------------------------------------
	// Wiper registers and tap decode
	// -----------------------------------------------------------------
	// Stored value is untouched by shutdown; only the tap output changes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			w1_q   <= MIDSCALE;                                       // RULE_22 RULE_23
			w2_q   <= MIDSCALE;                                       // RULE_22 RULE_23
			tap1_q <= dwss_tap(MIDSCALE);
			tap2_q <= dwss_tap(MIDSCALE);
		end else begin
			if (wr_one)
				w1_q <= shift_q;                                      // RULE_16
			if (wr_two)
				w2_q <= shift_q;                                      // RULE_16
			tap1_q <= sd_q ? TAP_B_END : dwss_tap(w1_q);              // RULE_14 RULE_15 RULE_21
			tap2_q <= sd_q ? TAP_B_END : dwss_tap(w2_q);              // RULE_14 RULE_15 RULE_21
		end
	end

	assign sda_out            = 1'b0;
	assign sda_oe             = oe_q;
	assign wiper_position_one = w1_q;
	assign wiper_position_two = w2_q;
	assign channel_select_bit = sel_q;
	assign shutdown_bit       = sd_q;
	assign terminal_a_open    = sd_q;                                 // RULE_14
	assign tap_select_one     = tap1_q;
	assign tap_select_two     = tap2_q;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	idle_holds_a: assert property ( // RULE_01
		(state_q == S_IDLE && !start_det) |=> state_q == S_IDLE)
		else $error("left idle without a start");

	stop_ends_a: assert property ( // RULE_02
		stop_det |=> (state_q == S_IDLE && !sda_oe))
		else $error("stop did not end the transfer");

	addr_ack_a: assert property ( // RULE_04
		(state_q == S_ADDR_ACK) |-> sda_oe)
		else $error("address acknowledge not driven");

	addr_miss_a: assert property ( // RULE_05
		(state_q == S_ADDR && byte_end && !addr_hit)
		|=> (state_q == S_WAIT_STOP && !sda_oe) [*2])
		else $error("foreign address was answered");

	data_ack_a: assert property ( // RULE_06
		(state_q == S_DATA && byte_end) |=> (sda_oe && state_q == S_DATA_ACK))
		else $error("written byte not acknowledged");

	tx_release_a: assert property ( // RULE_07
		(state_q == S_TX_ACK) |-> !sda_oe)
		else $error("data line held during master ack");

	nack_wait_a: assert property ( // RULE_08
		(state_q == S_TX_ACK && byte_end && !mack_q)
		|=> (state_q == S_WAIT_STOP && !sda_oe))
		else $error("kept sending after no acknowledge");

	instr_sel_a: assert property ( // RULE_13
		(state_q == S_INSTR && byte_end)
		|=> (sel_q == $past(shift_q[SEL_BIT]) && sd_q == $past(shift_q[SD_BIT])))
		else $error("instruction fields not latched");

	read_sel_a: assert property ( // RULE_19
		(state_q == S_ADDR_ACK && scl_fall && rw_q && !framing)
		|=> (state_q == S_TX && shift_q == $past(rd_val)))
		else $error("read did not load the selected wiper");

	wiper_load_a: assert property ( // RULE_16
		wr_one |=> ##1 (w1_q == $past(shift_q, 2) && sd_q == $past(sd_q, 2)))
		else $error("wiper one write lost");

	// The terminal flag follows the bit at once; the taps lag by one clock
	shut_tap_a: assert property ( // RULE_14
		sd_q |-> (terminal_a_open ##1 (tap_select_one == TAP_B_END
			&& tap_select_two == TAP_B_END)))
		else $error("shutdown did not park the wiper");

	restore_tap_a: assert property ( // RULE_15
		!sd_q |=> (tap_select_one == dwss_tap($past(w1_q))
			&& tap_select_two == dwss_tap($past(w2_q))))
		else $error("tap does not follow the wiper register");

	write_done_c: cover property (
		state_q == S_DATA_ACK ##[1:1000] stop_det);

	read_acked_c: cover property (
		state_q == S_TX_ACK && byte_end && mack_q);

	read_nack_c: cover property (
		state_q == S_TX_ACK ##1 state_q == S_WAIT_STOP);

	// The stop's own clock pulse counts as one stray bit
	sel_only_c: cover property (
		state_q == S_DATA && stop_det && cnt_q == 4'h1);

endmodule : dwss_slave

// >>> inc/dwss_pkg.sv
package dwss_pkg;

	// -----------------------------------------------------------------
	// Serial framing
	// -----------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int         RW_BIT    = 0;
	localparam int         SEL_BIT   = 7;
	localparam int         SD_BIT    = 6;

	// -----------------------------------------------------------------
	// Wiper reset and tap layout
	// -----------------------------------------------------------------
	localparam logic [7:0]   MIDSCALE   = 8'h80;
	localparam logic [255:0] TAP_B_END  = 256'h1;

	// -----------------------------------------------------------------
	// Slave sequencer states
	// -----------------------------------------------------------------
	typedef enum logic [9:0] {
		S_IDLE      = 10'h001,
		S_ADDR      = 10'h002,
		S_ADDR_ACK  = 10'h004,
		S_INSTR     = 10'h008,
		S_INSTR_ACK = 10'h010,
		S_DATA      = 10'h020,
		S_DATA_ACK  = 10'h040,
		S_TX        = 10'h080,
		S_TX_ACK    = 10'h100,
		S_WAIT_STOP = 10'h200
	} dwss_state_type;

	// One-of-256 tap select for a wiper position
	function automatic logic [255:0] dwss_tap(input logic [7:0] pos);
		dwss_tap = TAP_B_END << pos;
	endfunction : dwss_tap

endpackage : dwss_pkg

// >>> verification/dwss_master.sv
`timescale 1ns/100ps

// Two-wire bus master: clock stands high between frames, data has a pull-up
module dwss_master (
	input  wire logic clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl     = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	// Data moves only mid low phase; sampled late in the high phase so the
	// slave's synchroniser delay is covered
	task automatic bit_io(input logic b, output logic s);
		scl <= 1'b0;
		tick(2);
		sda_low <= ~b;
		tick(2);
		scl <= 1'b1;
		tick(3);
		s = sda;
		tick(1);
	endtask : bit_io

	task automatic start_c;
		scl <= 1'b0;
		tick(2);
		sda_low <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b1;
		tick(4);
	endtask : start_c

	task automatic stop_c;
		scl <= 1'b0;
		tick(2);
		sda_low <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_low <= 1'b0;
		tick(4);
	endtask : stop_c

	// Eight bits MSB first, then the ninth clock: nb low means we pull low
	task automatic byte_io(input logic [7:0] tx, input logic nb,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(nb, ack);
	endtask : byte_io
endmodule : dwss_master

// >>> verification/dwss_slave_tb.sv
`timescale 1ns/100ps

module dwss_slave_tb import dwss_pkg::*;;
	localparam logic [4:0] ID = 5'h15; // Arbitrary identifier value
	logic         clk;
	logic         rst;
	logic         strap_h;
	logic         strap_l;
	logic         m_scl;
	logic         m_low;
	logic         sda_oe;
	logic [7:0]   w1;
	logic [7:0]   w2;
	logic         sel;
	logic         sd;
	logic         a_open;
	logic [255:0] tap1;
	logic [255:0] tap2;
	logic [7:0]   rx;
	logic         ack;
	logic         sda_drv;
	wire          sda_w = ~((sda_oe & ~sda_drv) | m_low);
	int           fail_count = 0;
	int           checks = 0;
	int           cycles = 0;

	dwss_slave #(.ID_PREFIX(ID), .STRAP_EN(1'b1), .ID_LOW(2'h0)) u_dut (
		.clk(clk), .rst(rst), .scl_in(m_scl), .sda_in(sda_w),
		.sda_out(sda_drv), .sda_oe(sda_oe), .address_strap_high(strap_h),
		.address_strap_low(strap_l), .wiper_position_one(w1),
		.wiper_position_two(w2), .channel_select_bit(sel),
		.shutdown_bit(sd), .terminal_a_open(a_open),
		.tap_select_one(tap1), .tap_select_two(tap2));

	dwss_master u_mst (.clk(clk), .sda(sda_w), .scl(m_scl), .sda_low(m_low));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	// A whole run needs well under this many cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fail_count++;
			close_out();
		end
	end

	// ------------------------------
	// Bus helpers
	// ------------------------------
	task automatic check(input string what, input logic [255:0] seen,
		input logic [255:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	function automatic logic [255:0] one_hot(input logic [7:0] p);
		return 256'h1 << p;
	endfunction : one_hot

	function automatic logic [7:0] addr(input logic rw);
		return {ID, strap_h, strap_l, rw};
	endfunction : addr

	task automatic send(input logic [7:0] b, input logic exp_ack);
		u_mst.byte_io(b, 1'b1, rx, ack);
		check("ack", ack, exp_ack);
	endtask : send

	task automatic wr(input logic [7:0] ins, input logic [7:0] dat,
		input logic full);
		u_mst.start_c();
		send(addr(1'b0), 1'b0);
		send(ins, 1'b0);
		if (full)
			send(dat, 1'b0);
		u_mst.stop_c();
	endtask : wr

	task automatic rd(input logic [7:0] exp, input int n);
		u_mst.start_c();
		send(addr(1'b1), 1'b0);
		for (int i = 1; i <= n; i++) begin
			u_mst.byte_io(8'hFF, i == n, rx, ack);
			check("read data", rx, exp);
		end
		u_mst.byte_io(8'hFF, 1'b1, rx, ack);
		check("silent after nack", rx, 8'hFF);
		u_mst.stop_c();
	endtask : rd

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_reset;
		check("wiper one", w1, MIDSCALE);
		check("wiper two", w2, 8'h80);
		check("tap one", tap1, one_hot(8'h80));
		check("select", sel, 1'b0);
		check("a open", a_open, 1'b0);
		check("drive", sda_oe, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_write;
		wr(8'h2A, 8'h3C, 1'b1);
		check("wiper one", w1, 8'h3C);
		check("shutdown", sd, 1'b0);
		check("wiper two", w2, 8'h80);
		check("tap one", tap1, one_hot(8'h3C));
		wr(8'h95, 8'hA5, 1'b1);
		check("wiper two", w2, 8'hA5);
		check("select", sel, 1'b1);
		check("tap two", tap2, one_hot(8'hA5));
		$display("test write done");
	endtask : t_write

	task automatic t_read;
		rd(8'hA5, 3);
		wr(8'h00, 8'h00, 1'b0);
		check("wiper two", w2, 8'hA5);
		check("select", sel, 1'b0);
		rd(8'h3C, 1);
		$display("test read done");
	endtask : t_read

	task automatic t_shutdown;
		wr(8'h40, 8'h11, 1'b1);
		check("a open", a_open, 1'b1);
		check("shutdown", sd, 1'b1);
		check("tap one", tap1, 256'h1);
		check("tap two", tap2, 256'h1);
		check("wiper one", w1, 8'h11);
		wr(8'h00, 8'h00, 1'b0);
		check("a open", a_open, 1'b0);
		check("tap one", tap1, one_hot(8'h11));
		$display("test shutdown done");
	endtask : t_shutdown

	task automatic t_addr;
		u_mst.start_c();
		u_mst.byte_io({ID, ~strap_h, strap_l, 1'b0}, 1'b1, rx, ack);
		check("foreign ack", ack, 1'b1);
		u_mst.byte_io(8'h80, 1'b1, rx, ack);
		check("foreign byte ack", ack, 1'b1);
		u_mst.stop_c();
		check("select", sel, 1'b0);
		strap_h <= 1'b1;
		strap_l <= 1'b1;
		repeat (4) @(posedge clk);
		wr(8'h80, 8'h5A, 1'b1);
		check("wiper two", w2, 8'h5A);
		$display("test address done");
	endtask : t_addr

	initial begin
		rst = 1'b1;
		strap_h = 1'b0;
		strap_l = 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		t_write();
		t_read();
		t_shutdown();
		t_addr();
		// Wipers are volatile: a second reset must bring back midscale
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_reset();
		close_out();
	end
endmodule : dwss_slave_tb
